// File: rtl/asrc_pkg.sv
package asrc_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // timing in ns (slowest grade, power-up wait in us) and clock period
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS            = 40;
    localparam int SUPPLY_TO_FIRST_ACCESS_US = 100;
    localparam int ADDRESS_ACCESS_TIME_NS   = 15;
    localparam int OE_TO_DATA_NS            = 7;
    localparam int ADDRESS_TO_WRITE_END_NS  = 10;
    localparam int LANE_ENABLE_TO_WRITE_END_NS = 9;
    localparam int WRITE_DATA_SETUP_NS      = 8;
    localparam int WRITE_PULSE_NS           = 10;
    localparam int BUS_TURN_NS              = 7;

    // ------------------------------------------------------------
    // cycle counts, least times rounded up, at least one
    // ------------------------------------------------------------
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int POWER_UP_CYC =
        (SUPPLY_TO_FIRST_ACCESS_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int READ_CYC  = cyc_up(ADDRESS_ACCESS_TIME_NS) + 1;
    localparam int WRITE_CYC = cyc_up(WRITE_PULSE_NS);
    localparam int TURN_CYC  = cyc_up(BUS_TURN_NS);
    localparam int CNT_W     = 12;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ASRC_POWER,
        ASRC_IDLE,
        ASRC_READ,
        ASRC_WRITE,
        ASRC_TURN
    } asrc_state_t;

endpackage : asrc_pkg

// File: rtl/asrc_sync.sv
`timescale 1ns/10ps
module asrc_sync #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // --------------------------------------------------------
    // two flip-flop synchroniser
    // --------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : asrc_sync

// File: rtl/asrc_ctrl.sv
`timescale 1ns/10ps
// Function
// - write happens only while select, strobe and a lane enable are low
// - write ends at first rise of select, strobe or lane enable
// - data setup and hold measured to the terminating edge
// - wait at least 100 us after power before first access
// - strobe stays high during every read
// - address valid no later than select falling in a read
// - address may change at write start and end
// - address stable at least 10 ns before write end
// - lane enable low at least 9 ns before write end
// - write data valid at least 8 ns before write end
module asrc_ctrl #(
    parameter int POWER_UP_CYCLES = asrc_pkg::POWER_UP_CYC
) (
    // clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst,
    // user request
    input  wire logic                        i_req,
    input  wire logic                        i_we,
    input  wire logic [1:0]                  i_lanes,
    input  wire logic [asrc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [asrc_pkg::DATA_W-1:0] i_wdata,
    output logic                             o_ready,
    output logic                             o_rvalid,
    output logic      [asrc_pkg::DATA_W-1:0] o_rdata,
    // memory pins
    output logic                             o_chip_select_n,
    output logic                             o_output_enable_n,
    output logic                             o_write_strobe_n,
    output logic                             o_low_byte_enable_n,
    output logic                             o_high_byte_enable_n,
    output logic      [asrc_pkg::ADDR_W-1:0] o_addr,
    output logic      [asrc_pkg::DATA_W-1:0] o_data,
    output logic                             o_data_oe,
    input  wire logic [asrc_pkg::DATA_W-1:0] i_data
);

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    localparam int PCW = $clog2(POWER_UP_CYCLES + 1);

    asrc_pkg::asrc_state_t          st_q, st_d;
    logic [PCW-1:0]                 pwr_q, pwr_d;
    logic [asrc_pkg::CNT_W-1:0]     cnt_q, cnt_d;
    logic                           cs_n_q, cs_n_d;
    logic                           oe_n_q, oe_n_d;
    logic                           we_n_q, we_n_d;
    logic [1:0]                     be_n_q, be_n_d;
    logic [asrc_pkg::ADDR_W-1:0]    addr_q, addr_d;
    logic [asrc_pkg::DATA_W-1:0]    dout_q, dout_d;
    logic                           doe_q, doe_d;
    logic [asrc_pkg::DATA_W-1:0]    rdata_q, rdata_d;
    logic                           rvalid_q, rvalid_d;
    logic                           ready_q, ready_d;
    logic [asrc_pkg::DATA_W-1:0]    din_s;

    // --------------------------------------------------------
    // read data pins synchronised before use
    // --------------------------------------------------------
    asrc_sync #(
        .W (asrc_pkg::DATA_W)
    ) u_din_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_data),
        .o_sync    (din_s)
    );

    // --------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        pwr_d    = pwr_q;
        cnt_d    = cnt_q;
        cs_n_d   = cs_n_q;
        oe_n_d   = oe_n_q;
        we_n_d   = we_n_q;
        be_n_d   = be_n_q;
        addr_d   = addr_q;
        dout_d   = dout_q;
        doe_d    = doe_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        ready_d  = 1'b0;
        case (st_q)
            asrc_pkg::ASRC_POWER: begin
                if (pwr_q == PCW'(POWER_UP_CYCLES - 1)) begin
                    st_d    = asrc_pkg::ASRC_IDLE;
                    ready_d = 1'b1;
                end else begin
                    pwr_d = pwr_q + PCW'(1);
                end
            end
            asrc_pkg::ASRC_IDLE: begin
                ready_d = 1'b1;
                if (i_req) begin
                    ready_d = 1'b0;
                    addr_d  = i_addr;
                    cs_n_d  = 1'b0;
                    be_n_d  = ~i_lanes;
                    cnt_d   = '0;
                    if (i_we) begin
                        we_n_d = 1'b0;
                        dout_d = i_wdata;
                        doe_d  = 1'b1;
                        st_d   = asrc_pkg::ASRC_WRITE;
                    end else begin
                        we_n_d = 1'b1;
                        oe_n_d = 1'b0;
                        st_d   = asrc_pkg::ASRC_READ;
                    end
                end
            end
            // access time plus synchroniser in cycles
            asrc_pkg::ASRC_READ: begin
                if (cnt_q == asrc_pkg::CNT_W'(asrc_pkg::READ_CYC + 1)) begin
                    rdata_d  = din_s;
                    rvalid_d = 1'b1;
                    cs_n_d   = 1'b1;
                    oe_n_d   = 1'b1;
                    be_n_d   = 2'h3;
                    cnt_d    = '0;
                    st_d     = asrc_pkg::ASRC_TURN;
                end else begin
                    cnt_d = cnt_q + asrc_pkg::CNT_W'(1);
                end
            end
            // address and lanes held through the pulse
            asrc_pkg::ASRC_WRITE: begin
                if (cnt_q == asrc_pkg::CNT_W'(asrc_pkg::WRITE_CYC - 1)) begin
                    we_n_d = 1'b1;
                    cnt_d  = '0;
                    st_d   = asrc_pkg::ASRC_TURN;
                end else begin
                    cnt_d = cnt_q + asrc_pkg::CNT_W'(1);
                end
            end
            // data and address held past terminating edge
            asrc_pkg::ASRC_TURN: begin
                cs_n_d = 1'b1;
                be_n_d = 2'h3;
                doe_d  = 1'b0;
                if (cnt_q == asrc_pkg::CNT_W'(asrc_pkg::TURN_CYC - 1)) begin
                    st_d    = asrc_pkg::ASRC_IDLE;
                    ready_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + asrc_pkg::CNT_W'(1);
                end
            end
            default: begin
                st_d = asrc_pkg::ASRC_POWER;
            end
        endcase
    end

    // --------------------------------------------------------
    // registers
    // --------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q     <= asrc_pkg::ASRC_POWER;
            pwr_q    <= '0;
            cnt_q    <= '0;
            cs_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            be_n_q   <= 2'h3;
            addr_q   <= '0;
            dout_q   <= '0;
            doe_q    <= 1'b0;
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            ready_q  <= 1'b0;
        end else begin
            st_q     <= st_d;
            pwr_q    <= pwr_d;
            cnt_q    <= cnt_d;
            cs_n_q   <= cs_n_d;
            oe_n_q   <= oe_n_d;
            we_n_q   <= we_n_d;
            be_n_q   <= be_n_d;
            addr_q   <= addr_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            ready_q  <= ready_d;
        end
    end

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    assign o_chip_select_n      = cs_n_q;
    assign o_output_enable_n    = oe_n_q;
    assign o_write_strobe_n     = we_n_q;
    assign o_low_byte_enable_n  = be_n_q[0];
    assign o_high_byte_enable_n = be_n_q[1];
    assign o_addr               = addr_q;
    assign o_data               = dout_q;
    assign o_data_oe            = doe_q;
    assign o_rdata              = rdata_q;
    assign o_rvalid             = rvalid_q;
    assign o_ready              = ready_q;

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    property p_no_access_early;
        @(posedge i_sys_clk) disable iff (i_rst)
        (pwr_q < PCW'(POWER_UP_CYCLES - 1)) && st_q == asrc_pkg::ASRC_POWER
            |-> cs_n_q;
    endproperty
    a_no_access_early: assert property (p_no_access_early)
        else $error("access before power-up wait");

    property p_read_strobe_high;
        @(posedge i_sys_clk) disable iff (i_rst)
        !oe_n_q |-> we_n_q && !doe_q;
    endproperty
    a_read_strobe_high: assert property (p_read_strobe_high)
        else $error("strobe low or bus driven during read");

    property p_addr_at_select;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(cs_n_q) |-> addr_q == $past(i_addr);
    endproperty
    a_addr_at_select: assert property (p_addr_at_select)
        else $error("address not valid at select fall");

    property p_write_overlap;
        @(posedge i_sys_clk) disable iff (i_rst)
        !we_n_q |-> !cs_n_q && (be_n_q != 2'h3) && doe_q;
    endproperty
    a_write_overlap: assert property (p_write_overlap)
        else $error("strobe low without select, lane or data");

    property p_write_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(we_n_q) |-> $stable(addr_q) && doe_q && !cs_n_q;
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("data or address dropped at write end");

    property p_write_setup;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(we_n_q) |=> $stable(addr_q) && $stable(dout_q) && doe_q;
    endproperty
    a_write_setup: assert property (p_write_setup)
        else $error("address or data moved inside write pulse");

    property p_read_length;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(oe_n_q) |-> ##[1:20] o_rvalid;
    endproperty
    a_read_length: assert property (p_read_length)
        else $error("read did not complete");

    property p_lanes_in_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(we_n_q) |-> $past(be_n_q) == be_n_q;
    endproperty
    a_lanes_in_write: assert property (p_lanes_in_write)
        else $error("lane enable changed at write end");

endmodule : asrc_ctrl

// File: tb/asrc_sram_model.sv
`timescale 1ns/10ps
module asrc_sram_model #(
    parameter int ACC_NS = 15
) (
    // memory pins
    input  wire logic        i_chip_select_n,
    input  wire logic        i_output_enable_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic        i_low_byte_enable_n,
    input  wire logic        i_high_byte_enable_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data
);
    // ---------------------------------------------------------
    // storage and read path
    // ---------------------------------------------------------
    logic [15:0] mem [0:65535];
    logic [15:0] rd_q;
    logic [15:0] last_q = 16'h0000;
    logic [1:0]  drv;

    // lanes drive only in a read
    always_comb begin
        drv[0] = !i_chip_select_n && !i_output_enable_n
                 && i_write_strobe_n && !i_low_byte_enable_n;
        drv[1] = !i_chip_select_n && !i_output_enable_n
                 && i_write_strobe_n && !i_high_byte_enable_n;
    end

    // refresh on address change and strobe edges, so a word rewritten
    // at an unchanged address reads back fresh
    // data after access time
    always @(i_addr or i_write_strobe_n) rd_q <= #(ACC_NS) mem[i_addr];

    // released lanes show no stale value
    always @(negedge drv[0]) last_q[7:0] <= rd_q[7:0];
    always @(negedge drv[1]) last_q[15:8] <= rd_q[15:8];
    always_comb begin
        o_data[7:0]  = drv[0] ? rd_q[7:0] : ~last_q[7:0];
        o_data[15:8] = drv[1] ? rd_q[15:8] : ~last_q[15:8];
    end

    // store while all three are low
    always @* begin
        if (!i_chip_select_n && !i_write_strobe_n && !i_low_byte_enable_n) begin
            mem[i_addr][7:0] = i_data[7:0];
        end
        if (!i_chip_select_n && !i_write_strobe_n && !i_high_byte_enable_n) begin
            mem[i_addr][15:8] = i_data[15:8];
        end
    end
endmodule : asrc_sram_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    // ---------------------------------------------------------
    // clock, stimulus and wiring
    // ---------------------------------------------------------
    localparam int PWR = 4;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        req     = 1'b0;
    logic        we      = 1'b0;
    logic [1:0]  lanes   = 2'h0;
    logic [15:0] addr    = 16'h0000;
    logic [15:0] wdata   = 16'h0000;
    logic        ready, rvalid, cs_n, oe_n, wr_n, lo_n, hi_n, data_oe;
    logic [15:0] rdata, pin_addr, pin_data, mem_q, bus;
    int          failures = 0;
    int          checked  = 0;

    // clock inverted every half period
    always #20 sys_clk = ~sys_clk;
    // controller owns the bus while it drives, memory otherwise
    assign bus = data_oe ? pin_data : mem_q;

    asrc_ctrl #(.POWER_UP_CYCLES(PWR)) i_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_req(req), .i_we(we),
        .i_lanes(lanes), .i_addr(addr), .i_wdata(wdata),
        .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_chip_select_n(cs_n), .o_output_enable_n(oe_n),
        .o_write_strobe_n(wr_n), .o_low_byte_enable_n(lo_n),
        .o_high_byte_enable_n(hi_n), .o_addr(pin_addr),
        .o_data(pin_data), .o_data_oe(data_oe), .i_data(bus));

    asrc_sram_model i_mem (
        .i_chip_select_n(cs_n), .i_output_enable_n(oe_n),
        .i_write_strobe_n(wr_n), .i_low_byte_enable_n(lo_n),
        .i_high_byte_enable_n(hi_n), .i_addr(pin_addr),
        .i_data(bus), .o_data(mem_q));

    // ---------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic conclude;
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // wait at falling edges for ready, bounded
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (ready !== 1'b1) begin
            chk(16'h0000, 16'h0001, "ready never came");
            conclude();
        end
    endtask : wait_ready

    // hold a request until taken, leave at first cycle after
    task automatic issue(input logic w, input logic [1:0] ln,
                         input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        req = 1'b1;
        we = w;
        lanes = ln;
        addr = a;
        wdata = d;
        wait_ready();
        @(negedge sys_clk);
        req = 1'b0;
    endtask : issue

    task automatic do_write(input logic [1:0] ln, input logic [15:0] a,
                            input logic [15:0] d);
        issue(1'b1, ln, a, d);
        chk(16'({cs_n, oe_n, wr_n, hi_n, lo_n}), 16'({3'b010, ~ln}),
            "wr pins");
        chk(pin_addr, a, "write address");
        chk(16'({data_oe}), 16'h0001, "write drive");
        chk(pin_data, d, "write data");
        // strobe rises first, select and data stay one more cycle
        @(negedge sys_clk);
        chk(16'({cs_n, wr_n, data_oe}), 16'h0003, "write end order");
        chk(pin_addr, a, "address hold");
        wait_ready();
        chk(16'({cs_n, oe_n, wr_n, hi_n, lo_n, data_oe}), 16'h003E,
            "write release");
    endtask : do_write

    task automatic do_read(input logic [1:0] ln, input logic [15:0] a,
                           input logic [15:0] exp, input logic [15:0] m);
        int n;
        issue(1'b0, ln, a, 16'h0000);
        chk(16'({cs_n, oe_n, wr_n, hi_n, lo_n}), 16'({3'b001, ~ln}),
            "rd pins");
        chk(pin_addr, a, "read address");
        n = 1;
        while (rvalid !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        // pulse seen at the falling edge after count end, READ_CYC + 3 on
        chk(16'(n), 16'(asrc_pkg::READ_CYC + 3), "read latency");
        chk(rdata & m, exp & m, "read data");
        wait_ready();
        chk(16'({cs_n, oe_n, wr_n, hi_n, lo_n, data_oe}), 16'h003E,
            "read release");
    endtask : do_read

    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic t_power;
        int n;
        repeat (16) @(negedge sys_clk);
        chk(16'({ready, cs_n, wr_n, data_oe}), 16'h0006, "reset pins");
        rst = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk(16'(n >= PWR), 16'h0001, "power wait");
    endtask : t_power

    // lane writes and reads at the top and bottom address
    task automatic t_bytes;
        do_write(2'b11, 16'hFFFF, 16'hA55A);
        do_write(2'b10, 16'hFFFF, 16'h3CC3);
        do_read(2'b11, 16'hFFFF, 16'h3C5A, 16'hFFFF);
        do_read(2'b01, 16'hFFFF, 16'h3C5A, 16'h00FF);
        do_read(2'b10, 16'hFFFF, 16'h3C5A, 16'hFF00);
        do_write(2'b01, 16'h0000, 16'h0096);
        do_read(2'b01, 16'h0000, 16'h0096, 16'h00FF);
    endtask : t_bytes

    // request while busy is ignored, then back-to-back ops
    task automatic t_refuse;
        do_write(2'b11, 16'h0055, 16'h1111);
        issue(1'b1, 2'b11, 16'h0077, 16'h2222);
        // stray request lands while the write is still busy
        @(negedge sys_clk);
        req = 1'b1;
        addr = 16'h0055;
        wdata = 16'hFFFF;
        @(negedge sys_clk);
        req = 1'b0;
        wait_ready();
        do_read(2'b11, 16'h0055, 16'h1111, 16'hFFFF);
        do_read(2'b11, 16'h0077, 16'h2222, 16'hFFFF);
    endtask : t_refuse

    // no strobe or bus drive while the memory may drive
    always @(negedge sys_clk) begin
        if (!rst && cs_n === 1'b0 && oe_n === 1'b0) begin
            chk(16'({wr_n, data_oe}), 16'h0002, "drive clash");
        end
    end

    initial begin
        t_power();
        t_bytes();
        t_refuse();
        conclude();
    end
endmodule : testbench
